// ---- test/gfch_asserts.sv ----
// checker for the configuration header top ports
// assumes it is bound onto gfch_top, one clock domain
`timescale 1ns/10ps
module gfch_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // config bus
    input wire logic cfg_req,
    input wire gfch_pkg::gfch_cfg_req_t cfg_cmd,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // controls and decode
    input wire logic host_device_enable_bit4,
    input wire logic graphics_function_enable,
    input wire logic io_access_enable,
    input wire logic io_req,
    input wire gfch_pkg::gfch_io_req_t io_cmd,
    input wire logic io_claim,
    input wire logic [1:0] power_state,
    input wire logic gfx_reinit
);
    import gfch_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // request decode
    wire rd = cfg_req && !cfg_cmd.we;
    wire [5:0] dw = cfg_cmd.addr[7:2];
    wire st_wr = cfg_req && cfg_cmd.we && dw == 6'h35 && cfg_cmd.be[0];
    // ==========================================================
    // assertions
    a_ack_after_req: assert property (cfg_req |=> cfg_ack)
        else $error("no ack after request");
    a_hdr_mirror: assert property (rd && dw == 6'h03 |=>
        cfg_rdata == {8'h00, $past(host_device_enable_bit4), 23'h0})
        else $error("header dword wrong");
    a_io_bar_low: assert property (rd && dw == 6'h05 |=>
        cfg_rdata[31:16] == 16'h0 && cfg_rdata[2:0] == 3'h1)
        else $error("io base fixed bits wrong");
    a_aper_low: assert property (rd && dw == 6'h06 |=>
        cfg_rdata[27:0] == 28'h0000008)
        else $error("aperture fixed bits wrong");
    a_rom_zero: assert property (rd && dw == 6'h0c |=>
        cfg_rdata == 32'h0)
        else $error("rom base not zero");
    a_cap_ptr: assert property (rd && dw == 6'h0d |=>
        cfg_rdata == 32'h000000d0)
        else $error("capability pointer wrong");
    a_pin_grant: assert property (rd && dw == 6'h0f |=>
        cfg_rdata[31:8] == 24'h000001)
        else $error("pin or grant bytes wrong");
    a_pm_words: assert property (rd && dw == 6'h34 |=>
        cfg_rdata == 32'h00220001)
        else $error("power capability words wrong");
    a_pm_status: assert property (rd && dw == 6'h35 |=>
        cfg_rdata == {30'h0, power_state})
        else $error("power status word wrong");
    a_state_drop: assert property (st_wr &&
        cfg_cmd.wdata[0] != cfg_cmd.wdata[1] |=> $stable(power_state))
        else $error("unsupported state taken");
    a_io_gate: assert property (io_claim |-> io_req &&
        io_access_enable && graphics_function_enable &&
        power_state == 2'b00 && io_cmd.size != 2'd3)
        else $error("io claimed while refused");
    a_reinit_wake: assert property (st_wr &&
        cfg_cmd.wdata[1:0] == 2'b00 && power_state == 2'b11
        |-> ##[1:2] gfx_reinit)
        else $error("no reinit on wake");
    a_reinit_pulse: assert property (gfx_reinit |=> !gfx_reinit)
        else $error("reinit longer than a cycle");
    // ==========================================================
    // coverage
    c_io_claim: cover property (io_claim);
    c_reinit: cover property (gfx_reinit);
    c_drop: cover property (st_wr && cfg_cmd.wdata[1:0] == 2'b01);
endmodule // gfch_asserts

bind gfch_top gfch_asserts chk_u (.core_clk, .nrst, .cfg_req, .cfg_cmd,
    .cfg_ack, .cfg_rdata, .host_device_enable_bit4,
    .graphics_function_enable, .io_access_enable, .io_req, .io_cmd,
    .io_claim, .power_state, .gfx_reinit);

// ---- test/gfch_host_bfm.sv ----
// host bridge model issuing single configuration requests
// assumes the ack arrives on the taking edge, one cycle after the request is driven
`timescale 1ns/10ps
module gfch_host_bfm (
    // clock
    input wire logic core_clk,
    // request
    output gfch_pkg::gfch_cfg_req_t cfg_cmd,
    output logic cfg_req,
    // answer
    input wire logic cfg_ack,
    input wire logic cfg_hit,
    input wire logic [31:0] cfg_rdata
);
    import gfch_pkg::*;
    initial begin
        cfg_req = 1'b0;
        cfg_cmd = '0;
    end
    // request lasts one cycle: holding it would issue a second one
    task automatic xfer(input logic we, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d,
        output logic [31:0] q, output logic h, output logic k);
        @(posedge core_clk);
        cfg_req <= 1'b1;
        cfg_cmd <= '{we, a, be, d};
        @(posedge core_clk);
        cfg_req <= 1'b0;
        // stale payload is scrambled so nothing relies on it
        cfg_cmd <= ~cfg_cmd;
        #1;
        k = cfg_ack;
        h = cfg_hit;
        q = cfg_rdata;
    endtask
endmodule // gfch_host_bfm

// ---- test/gfch_tb_top.sv ----
// self-checking bench for the configuration header
// assumes gfch_top, the host bridge model and the bound checker
`timescale 1ns/10ps
module gfch_tb_top;
    import gfch_pkg::*;
    // ==========================================================
    // clock, reset and ports
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_req, cfg_ack, cfg_hit, io_claim, gfx_reinit;
    logic host_device_enable_bit4, graphics_function_enable;
    logic io_access_enable, mem_access_enable, io_req;
    logic reg_window_hit, aperture_hit, xlat_table_hit;
    gfch_cfg_req_t cfg_cmd;
    gfch_io_req_t io_cmd;
    logic [31:0] cfg_rdata, mem_addr;
    logic [1:0] power_state;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] m [64];
    logic lk_v, lk_i;
    always #10 core_clk = ~core_clk;
    gfch_top dut_u (.core_clk, .nrst, .cfg_req, .cfg_cmd, .cfg_ack,
        .cfg_hit, .cfg_rdata, .host_device_enable_bit4,
        .graphics_function_enable, .io_access_enable, .mem_access_enable,
        .io_req, .io_cmd, .io_claim, .mem_addr, .reg_window_hit,
        .aperture_hit, .xlat_table_hit, .power_state, .gfx_reinit);
    gfch_host_bfm bfm_u (.core_clk, .cfg_cmd, .cfg_req, .cfg_ack,
        .cfg_hit, .cfg_rdata);
    // ==========================================================
    // reference model
    function automatic logic [31:0] wmask(int d);
        case (d)
            4: return 32'hfff80000;
            5: return 32'h0000fff8;
            6: return 32'hf0000000;
            7: return 32'hfffc0000;
            11: return {lk_i ? 16'h0 : 16'hffff, lk_v ? 16'h0 : 16'hffff};
            15: return 32'h000000ff;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] expv(int d);
        case (d)
            3: return {8'h00, host_device_enable_bit4, 23'h0};
            5: return m[5] | 32'h1;
            6: return m[6] | 32'h8;
            13: return 32'hd0;
            15: return m[15] | 32'h100;
            52: return 32'h00220001;
            default: return m[d];
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ==========================================================
    // stimulus: side inputs are stirred before every access
    task automatic stir();
        logic [31:0] r, q;
        r = $urandom;
        q = $urandom;
        @(posedge core_clk);
        host_device_enable_bit4 <= r[0];
        graphics_function_enable <= r[3:1] != 3'h0;
        io_access_enable <= r[5:4] != 2'h0;
        mem_access_enable <= r[7:6] != 2'h0;
        io_req <= r[8];
        io_cmd <= '{r[9] ? {m[5][15:3], r[12:10]} : r[31:16], r[14:13]};
        mem_addr <= {q[31] ? m[4][31:19] : q[30] ? m[6][31:19] :
            m[7][31:19], q[18:0]};
    endtask
    task automatic acc(input logic we, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q, wm;
        logic h, k, me;
        int i;
        i = a[7:2];
        stir();
        bfm_u.xfer(we, a, be, d, q, h, k);
        chk({31'h0, k}, 32'h1);
        chk({31'h0, h}, {31'h0, i inside {[3:15], [52:53]}});
        if (we) begin
            chk(q, 32'h0);
            wm = wmask(i) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            m[i] = (m[i] & ~wm) | (d & wm);
            if (i == 11) begin
                lk_v |= |be[1:0];
                lk_i |= |be[3:2];
            end
            if (i == 53 && be[0] && d[1:0] inside {2'b00, 2'b11})
                m[53] = {30'h0, d[1:0]};
        end else
            chk(q, expv(i));
        me = mem_access_enable && graphics_function_enable;
        chk({29'h0, reg_window_hit, aperture_hit, xlat_table_hit},
            {29'h0, me && mem_addr[31:19] == m[4][31:19],
            me && mem_addr[31:28] == m[6][31:28],
            me && mem_addr[31:18] == m[7][31:18]});
        chk({31'h0, io_claim}, {31'h0, io_req && io_access_enable &&
            graphics_function_enable && m[53][1:0] == 2'b00 &&
            io_cmd.size != 2'd3 && io_cmd.addr[15:3] == m[5][15:3]});
        chk({30'h0, power_state}, m[53]);
    endtask
    task automatic rst();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        m = '{default: '0};
        lk_v = 1'b0;
        lk_i = 1'b0;
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        {host_device_enable_bit4, graphics_function_enable} = 2'b11;
        {io_access_enable, mem_access_enable, io_req} = 3'b111;
        io_cmd = '0;
        mem_addr = 32'h0;
        void'($urandom(32'hd22753fa));
        rst();
        for (int i = 0; i < 64; i++) acc(1'b0, 8'(i * 4), 4'h0, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 64; i++) acc(1'b1, 8'(i * 4), 4'hf, '1);
        for (int i = 0; i < 64; i++) acc(1'b0, 8'(i * 4), 4'h0, 32'h0);
        $display("test write ones done");
        // second reset mid-run: identifiers must unlock
        rst();
        acc(1'b1, 8'h2c, 4'b0001, 32'h12345678);
        acc(1'b1, 8'h2c, 4'hf, 32'hffffffff);
        acc(1'b0, 8'h2c, 4'h0, 32'h0);
        $display("test write once done");
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 8'hd4, 4'h1, 32'(c));
            acc(1'b1, 8'hd4, 4'h1, 32'h3);
            acc(1'b1, 8'hd4, 4'h3, 32'h0000ff00 | 32'(c));
            acc(1'b0, 8'hd4, 4'h0, 32'h0);
        end
        $display("test power states done");
        for (int n = 0; n < 300; n++) begin
            logic [31:0] r;
            int i;
            r = $urandom;
            i = r[0] ? 3 + r[7:4] % 13 : r[7:2];
            if (r[9:8] == 2'b00)
                i = 52 + r[10];
            acc(r[11], 8'(i * 4), r[15:12], $urandom);
        end
        $display("test random traffic done");
        end_sim();
    end
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
endmodule // gfch_tb_top

// ---- verilog/gfch_pkg.sv ----
// constants, field layouts and carrier types for the graphics function
// configuration header (offsets 0dh to d5h of a type 0 header)
// assumes byte addressed configuration space, dword wide data path
package gfch_pkg;

    // ==========================================================
    // byte offsets of the header registers
    localparam logic [7:0] OFS_BUS_LATENCY_TIMER = 8'h0d;
    localparam logic [7:0] OFS_HEADER_TYPE = 8'h0e;
    localparam logic [7:0] OFS_REGISTER_WINDOW_BASE = 8'h10;
    localparam logic [7:0] OFS_IO_WINDOW_BASE = 8'h14;
    localparam logic [7:0] OFS_APERTURE_BASE = 8'h18;
    localparam logic [7:0] OFS_TRANSLATION_TABLE_BASE = 8'h1c;
    localparam logic [7:0] OFS_SUBSYSTEM_VENDOR_ID = 8'h2c;
    localparam logic [7:0] OFS_SUBSYSTEM_ID = 8'h2e;
    localparam logic [7:0] OFS_OPTION_ROM_BASE = 8'h30;
    localparam logic [7:0] OFS_CAPABILITY_LIST_POINTER = 8'h34;
    localparam logic [7:0] OFS_INTERRUPT_ROUTING_LINE = 8'h3c;
    localparam logic [7:0] OFS_INTERRUPT_PIN_SELECT = 8'h3d;
    localparam logic [7:0] OFS_MINIMUM_GRANT = 8'h3e;
    localparam logic [7:0] OFS_MAXIMUM_LATENCY = 8'h3f;
    localparam logic [7:0] OFS_POWER_CAP_HEADER = 8'hd0;
    localparam logic [7:0] OFS_POWER_CAPABILITIES = 8'hd2;
    localparam logic [7:0] OFS_POWER_CONTROL_STATUS = 8'hd4;

    // ==========================================================
    // constant and reset values
    localparam logic [7:0] RST_BUS_LATENCY_TIMER = 8'h00;
    localparam logic [6:0] RST_HEADER_CODE = 7'h00;
    localparam logic [7:0] RST_CAPABILITY_LIST_POINTER = 8'hd0;
    localparam logic [7:0] RST_INTERRUPT_ROUTING_LINE = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_PIN_SELECT = 8'h01;
    localparam logic [7:0] RST_MINIMUM_GRANT = 8'h00;
    localparam logic [7:0] RST_MAXIMUM_LATENCY = 8'h00;
    localparam logic [7:0] RST_CAPABILITY_IDENTIFIER = 8'h01;
    localparam logic [7:0] RST_NEXT_CAPABILITY_POINTER = 8'h00;
    localparam logic [15:0] RST_POWER_CAPABILITIES = 16'h0022;
    localparam logic [15:0] RST_SUBSYSTEM_ID = 16'h0000;
    localparam logic [31:0] RST_OPTION_ROM_BASE = 32'h0000_0000;

    // ==========================================================
    // writable base fields: width and lowest bit
    localparam int REG_WIN_LSB = 19;
    localparam int IO_WIN_LSB = 3;
    localparam int IO_WIN_MSB = 15;
    localparam int APERTURE_LSB = 28;
    localparam int XLAT_LSB = 18;
    // hardwired low bits of each base register
    localparam logic [18:0] REG_WIN_LOW = 19'h0_0000;
    localparam logic [2:0] IO_WIN_LOW = 3'h1;
    localparam logic [27:0] APERTURE_LOW = 28'h000_0008;
    localparam logic [17:0] XLAT_LOW = 18'h0_0000;
    localparam int HDR_MULTI_FUNC_BIT = 7;

    // ==========================================================
    // power states and build options
    typedef enum logic [1:0] {
        GFCH_D0 = 2'b00,
        GFCH_D1 = 2'b01,
        GFCH_D2 = 2'b10,
        GFCH_D3 = 2'b11
    } gfch_pstate_t;
    localparam logic REINIT_ON_D3_EXIT = 1'b1;
    localparam int NUM_SUBSYS_IDS = 2;

    // ==========================================================
    // carrier of one configuration request
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } gfch_cfg_req_t;

    // carrier of one processor i/o cycle
    typedef struct packed {
        logic [15:0] addr;
        logic [1:0] size;
    } gfch_io_req_t;

endpackage

// ---- verilog/gfch_rst_sync.sv ----
// reset release synchroniser for the configuration header
// assumes an asynchronous active low reset from the platform
`timescale 1ns/10ps
module gfch_rst_sync (
    // clock and raw reset
    input wire logic core_clk,
    input wire logic nrst,
    // synchronised reset
    output logic rst_n_sync
);
    import gfch_pkg::*;

    logic meta_r;
    logic sync_r;

    // ==========================================================
    // assert at once, release after two edges
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            sync_r <= meta_r;
        end
    end

    assign rst_n_sync = sync_r;

endmodule // gfch_rst_sync

// ---- verilog/gfch_top.sv ----
// upper configuration header of the graphics function: base windows,
// subsystem identifiers, interrupt bytes and power management
// assumes the host bridge presents one dword config request per cycle
// and that command and enable bits come from logic on core_clk
`timescale 1ns/10ps

// Contract
// - latency timer reads zero, writes ignored
// - multi-function bit mirrors host enable bit four
// - register window base bits 31:19 writable
// - io base bits 15:3 writable, bit0 one
// - io window only in D0 with io enable
// - claim 8/16/32-bit io cycles inside window
// - io decode ignores legacy vga setting
// - aperture base bits 31:28, prefetchable bit set
// - translation table base bits 31:18 writable
// - subsystem identifiers write once until reset
// - option rom base reads all zero
// - capability pointer reads d0h
// - interrupt line plain read/write byte
// - interrupt pin reads 01h
// - minimum grant and maximum latency read zero
// - capability id 01h, next pointer 00h
// - power capabilities word reads 0022h
// - power state holds; codes 01/10 dropped
// - wake event status and enable read zero
// - optional reinit pulse on D3 to D0
module gfch_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // configuration access from the host bridge
    input wire logic cfg_req,
    input wire gfch_pkg::gfch_cfg_req_t cfg_cmd,
    output logic cfg_ack,
    output logic cfg_hit,
    output logic [31:0] cfg_rdata,
    // controls from neighbouring header and host function
    input wire logic host_device_enable_bit4,
    input wire logic graphics_function_enable,
    input wire logic io_access_enable,
    input wire logic mem_access_enable,
    // processor i/o cycle decode
    input wire logic io_req,
    input wire gfch_pkg::gfch_io_req_t io_cmd,
    output logic io_claim,
    // memory cycle decode
    input wire logic [31:0] mem_addr,
    output logic reg_window_hit,
    output logic aperture_hit,
    output logic xlat_table_hit,
    // power state to the graphics engine
    output logic [1:0] power_state,
    output logic gfx_reinit
);
    import gfch_pkg::*;

    // ==========================================================
    // reset
    logic rst_n;

    gfch_rst_sync u_rst_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .rst_n_sync(rst_n)
    );

    // ==========================================================
    // request decode
    logic [5:0] dw;
    logic wr_stb;
    logic sel_0c;
    logic sel_10;
    logic sel_14;
    logic sel_18;
    logic sel_1c;
    logic sel_2c;
    logic sel_30;
    logic sel_34;
    logic sel_3c;
    logic sel_d0;
    logic sel_d4;
    logic [3:0] be;
    logic [31:0] wd;

    assign dw = cfg_cmd.addr[7:2];
    assign be = cfg_cmd.be;
    assign wd = cfg_cmd.wdata;
    assign wr_stb = cfg_req && cfg_cmd.we;
    assign sel_0c = (dw == OFS_BUS_LATENCY_TIMER[7:2]);
    assign sel_10 = (dw == OFS_REGISTER_WINDOW_BASE[7:2]);
    assign sel_14 = (dw == OFS_IO_WINDOW_BASE[7:2]);
    assign sel_18 = (dw == OFS_APERTURE_BASE[7:2]);
    assign sel_1c = (dw == OFS_TRANSLATION_TABLE_BASE[7:2]);
    assign sel_2c = (dw == OFS_SUBSYSTEM_VENDOR_ID[7:2]);
    assign sel_30 = (dw == OFS_OPTION_ROM_BASE[7:2]);
    assign sel_34 = (dw == OFS_CAPABILITY_LIST_POINTER[7:2]);
    assign sel_3c = (dw == OFS_INTERRUPT_ROUTING_LINE[7:2]);
    assign sel_d0 = (dw == OFS_POWER_CAP_HEADER[7:2]);
    assign sel_d4 = (dw == OFS_POWER_CONTROL_STATUS[7:2]);

    // this block owns 0dh..3fh and d0h..d5h; the rest of dword 0ch
    // and 40h..cfh belong to the neighbours or read zero
    logic in_range;

    assign in_range = (dw >= OFS_BUS_LATENCY_TIMER[7:2] &&
                       dw <= OFS_MAXIMUM_LATENCY[7:2]) ||
                      sel_d0 || sel_d4;

    // ==========================================================
    // base registers: only the writable base bits are stored
    logic [31:REG_WIN_LSB] reg_win_r;
    logic [31:REG_WIN_LSB] reg_win_nxt;
    logic [IO_WIN_MSB:IO_WIN_LSB] io_win_r;
    logic [IO_WIN_MSB:IO_WIN_LSB] io_win_nxt;
    logic [31:APERTURE_LSB] aper_r;
    logic [31:APERTURE_LSB] aper_nxt;
    logic [31:XLAT_LSB] xlat_r;
    logic [31:XLAT_LSB] xlat_nxt;

    // byte lanes 2 and 3 carry bits 31:19
    assign reg_win_nxt = {be[3] ? wd[31:24] : reg_win_r[31:24],
                          be[2] ? wd[23:19] : reg_win_r[23:19]};
    // lanes 0 and 1; bits 2:0 and 31:16 never stored
    assign io_win_nxt = {be[1] ? wd[15:8] : io_win_r[15:8],
                         be[0] ? wd[7:3] : io_win_r[7:3]};
    assign aper_nxt = be[3] ? wd[31:28] : aper_r;
    assign xlat_nxt = {be[3] ? wd[31:24] : xlat_r[31:24],
                       be[2] ? wd[23:18] : xlat_r[23:18]};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_win_r <= '0;
            io_win_r <= '0;
            aper_r <= '0;
            xlat_r <= '0;
        end else begin
            if (wr_stb && sel_10) begin
                reg_win_r <= reg_win_nxt;
            end
            if (wr_stb && sel_14) begin
                io_win_r <= io_win_nxt;
            end
            if (wr_stb && sel_18) begin
                aper_r <= aper_nxt;
            end
            if (wr_stb && sel_1c) begin
                xlat_r <= xlat_nxt;
            end
        end
    end

    // ==========================================================
    // subsystem identifiers: vendor in lanes 1:0, subsystem in 3:2
    logic [15:0] subsys_val [NUM_SUBSYS_IDS];
    logic [NUM_SUBSYS_IDS-1:0] subsys_locked;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SUBSYS_IDS; gi++) begin : g_subsys
            gfch_wo_reg u_wo (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .wr_en(wr_stb && sel_2c),
                .be(be[2*gi+1 -: 2]),
                .wdata(wd[16*gi+15 -: 16]),
                .value(subsys_val[gi]),
                .locked(subsys_locked[gi])
            );
        end
    endgenerate

    // ==========================================================
    // interrupt routing byte, storage only
    logic [7:0] int_line_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_line_r <= RST_INTERRUPT_ROUTING_LINE;
        end else if (wr_stb && sel_3c && be[0]) begin
            int_line_r <= wd[7:0];
        end
    end

    // ==========================================================
    // power state
    gfch_pstate_t pstate_r;
    gfch_pstate_t pstate_nxt;
    logic ps_wr;
    logic ps_legal;
    logic d3_exit;
    logic reinit_r;

    assign ps_wr = wr_stb && sel_d4 && be[0];
    // D1 and D2 are not supported: the write completes, data dropped
    assign ps_legal = (wd[1:0] == GFCH_D0) || (wd[1:0] == GFCH_D3);
    assign pstate_nxt = gfch_pstate_t'(wd[1:0]);
    assign d3_exit = ps_wr && ps_legal &&
                     (pstate_r == GFCH_D3) && (pstate_nxt == GFCH_D0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pstate_r <= GFCH_D0;
        end else if (ps_wr && ps_legal) begin
            pstate_r <= pstate_nxt;
        end
    end

    // one-cycle pulse; the engine decides what initial values mean
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reinit_r <= 1'b0;
        end else begin
            reinit_r <= d3_exit && REINIT_ON_D3_EXIT;
        end
    end

    assign power_state = pstate_r;
    assign gfx_reinit = reinit_r;

    // ==========================================================
    // read data assembly
    logic [7:0] hdr_type;
    logic [31:0] rd_0c;
    logic [31:0] rd_10;
    logic [31:0] rd_14;
    logic [31:0] rd_18;
    logic [31:0] rd_1c;
    logic [31:0] rd_2c;
    logic [31:0] rd_30;
    logic [31:0] rd_34;
    logic [31:0] rd_3c;
    logic [31:0] rd_d0;
    logic [31:0] rd_d4;
    logic [31:0] rd_mux;

    // live copy, no latch: follows the host enable at every read
    assign hdr_type = {host_device_enable_bit4, RST_HEADER_CODE};
    // bytes 0ch and 0fh are outside this block and read zero here
    assign rd_0c = {8'h00, hdr_type,
                    RST_BUS_LATENCY_TIMER, 8'h00};
    assign rd_10 = {reg_win_r, REG_WIN_LOW};
    assign rd_14 = {16'h0000, io_win_r, IO_WIN_LOW};
    assign rd_18 = {aper_r, APERTURE_LOW};
    assign rd_1c = {xlat_r, XLAT_LOW};
    assign rd_2c = {subsys_val[1], subsys_val[0]};
    assign rd_30 = RST_OPTION_ROM_BASE;
    assign rd_34 = {24'h00_0000, RST_CAPABILITY_LIST_POINTER};
    assign rd_3c = {RST_MAXIMUM_LATENCY, RST_MINIMUM_GRANT,
                    RST_INTERRUPT_PIN_SELECT,
                    int_line_r};
    assign rd_d0 = {RST_POWER_CAPABILITIES,
                    RST_NEXT_CAPABILITY_POINTER,
                    RST_CAPABILITY_IDENTIFIER};
    // wake event bits 15 and 8 and all reserved bits stay zero
    assign rd_d4 = {16'h0000, 14'h0000, pstate_r};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_0c) begin
            rd_mux = rd_0c;
        end else if (sel_10) begin
            rd_mux = rd_10;
        end else if (sel_14) begin
            rd_mux = rd_14;
        end else if (sel_18) begin
            rd_mux = rd_18;
        end else if (sel_1c) begin
            rd_mux = rd_1c;
        end else if (sel_2c) begin
            rd_mux = rd_2c;
        end else if (sel_30) begin
            rd_mux = rd_30;
        end else if (sel_34) begin
            rd_mux = rd_34;
        end else if (sel_3c) begin
            rd_mux = rd_3c;
        end else if (sel_d0) begin
            rd_mux = rd_d0;
        end else if (sel_d4) begin
            rd_mux = rd_d4;
        end
    end

    // ==========================================================
    // answer: one cycle after the request, data held until next
    logic ack_r;
    logic hit_r;
    logic [31:0] rdata_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            hit_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= cfg_req;
            if (cfg_req) begin
                hit_r <= in_range;
                // writes return zero data so the bus sees no stale value
                rdata_r <= cfg_cmd.we ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign cfg_ack = ack_r;
    assign cfg_hit = hit_r;
    assign cfg_rdata = rdata_r;

    // ==========================================================
    // i/o window decode; vga compatibility deliberately not an input
    logic io_allowed;
    logic io_in_win;
    logic io_size_ok;

    assign io_allowed = (pstate_r == GFCH_D0) && io_access_enable &&
                        graphics_function_enable;
    assign io_in_win = (io_cmd.addr[IO_WIN_MSB:IO_WIN_LSB] ==
                        io_win_r);
    // sizes 0,1,2 are byte, word, dword; code 3 is never claimed
    assign io_size_ok = (io_cmd.size != 2'h3);
    assign io_claim = io_req && io_allowed && io_in_win &&
                      io_size_ok;

    // ==========================================================
    // memory window decode; overlap between windows is software's
    // problem, each hit is reported independently
    logic mem_ok;

    assign mem_ok = mem_access_enable && graphics_function_enable;
    assign reg_window_hit = mem_ok &&
                            (mem_addr[31:REG_WIN_LSB] == reg_win_r);
    assign aperture_hit = mem_ok &&
                          (mem_addr[31:APERTURE_LSB] == aper_r);
    assign xlat_table_hit = mem_ok &&
                            (mem_addr[31:XLAT_LSB] == xlat_r);

endmodule // gfch_top

// ---- verilog/gfch_wo_reg.sv ----
// one 16-bit write-once register with byte enables
// assumes writes arrive as single-cycle strobes on core_clk
`timescale 1ns/10ps
module gfch_wo_reg (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // write strobe
    input wire logic wr_en,
    input wire logic [1:0] be,
    input wire logic [15:0] wdata,
    // state
    output logic [15:0] value,
    output logic locked
);
    import gfch_pkg::*;

    logic [15:0] value_r;
    logic locked_r;
    logic wr_ok;
    logic [15:0] merged;

    // ==========================================================
    // any enabled byte counts as the one write; only reset unlocks
    assign wr_ok = wr_en && (be != 2'h0) && !locked_r;
    assign merged = {be[1] ? wdata[15:8] : value_r[15:8],
                     be[0] ? wdata[7:0] : value_r[7:0]};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= RST_SUBSYSTEM_ID;
            locked_r <= 1'b0;
        end else if (wr_ok) begin
            value_r <= merged;
            locked_r <= 1'b1;
        end
    end

    assign value = value_r;
    assign locked = locked_r;

endmodule // gfch_wo_reg
